// file: wdrt_consts.svh
// Constants for the watchdog reload timer: offsets, reset values, field bits, timing
`ifndef WDRT_CONSTS_SVH
`define WDRT_CONSTS_SVH

// ****************************************
// Register offsets
// ****************************************
`define WDRT_ADDR_RLD_HI 8'h00
`define WDRT_ADDR_RLD_LO 8'h01
`define WDRT_ADDR_CTRL 8'h02
`define WDRT_ADDR_STATUS 8'h03
`define WDRT_ADDR_IRQ_STAT 8'h04
`define WDRT_ADDR_IRQ_MASK 8'h05
`define WDRT_ADDR_CNT_HI 8'h06
`define WDRT_ADDR_CNT_LO 8'h07

// ****************************************
// Reset values
// ****************************************
`define WDRT_RELOAD_RST 16'h0400
`define WDRT_RLD_HI_RST 8'h04
`define WDRT_RLD_LO_RST 8'h00
`define WDRT_RESP_RST 1'h0
`define WDRT_BYTE_ZERO 8'h00
`define WDRT_CNT_ONE 16'h0001

// ****************************************
// Field positions
// ****************************************
`define WDRT_CTRL_RESP_BIT 0
`define WDRT_STAT_RUN_BIT 0
`define WDRT_STAT_RESP_BIT 1
`define WDRT_STAT_AO_BIT 2
`define WDRT_IRQ_TO_BIT 0

// ****************************************
// Timing
// ****************************************
`define WDRT_CLK_HZ 200000000
`define WDRT_OSC_HZ 10000
`define WDRT_OSC_DIV (`WDRT_CLK_HZ / `WDRT_OSC_HZ)

`endif

// file: wdrt_pkg.sv
// Types shared by the watchdog reload timer modules
`default_nettype none
package wdrt_pkg;

    typedef logic [7:0] wdrt_byte_t;

    // Response taken when the count runs out
    typedef enum logic {
        WDRT_RESP_SYS_RESET,
        WDRT_RESP_INTERRUPT
    } wdrt_resp_t;

    // State of the main counter block
    typedef struct packed {
        logic [7:0] rld_hi;
        logic [7:0] rld_lo;
        logic resp;
        logic run;
        logic [15:0] cnt;
        logic rst_req;
        logic [7:0] rdata;
    } wdrt_st_t;

    // State of the oscillator tick divider
    typedef struct packed {
        logic [31:0] div;
        logic tick;
    } wdrt_osc_st_t;

    // State of the interrupt status block
    typedef struct packed {
        logic [7:0] stat;
        logic [7:0] mask;
    } wdrt_irq_st_t;

endpackage : wdrt_pkg
`default_nettype wire

// file: wdrt_osc.sv
// Watchdog oscillator tick generator derived from the system clock
`timescale 1ns/1ps
`default_nettype none
`include "wdrt_consts.svh"

module wdrt_osc #(
    parameter int unsigned OSC_DIV = `WDRT_OSC_DIV
) (
    input wire logic clk_sys,
    input wire logic nrst,
    output logic osc_tick
);
    import wdrt_pkg::*;

    wdrt_osc_st_t st_r;
    wdrt_osc_st_t st_nxt;

    // Divide down to the nominal watchdog oscillator rate; one pulse per period
    always_comb begin
        st_nxt = st_r;
        st_nxt.tick = 1'b0;
        if (st_r.div >= 32'(OSC_DIV - 1)) begin
            st_nxt.div = '0;
            st_nxt.tick = 1'b1; // RULE_07
        end else begin
            st_nxt.div = 32'(st_r.div + 32'h1);
        end
    end

    // State register
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign osc_tick = st_r.tick;

    // Ticks are spaced by many system cycles
    property p_tick_gap;
        @(posedge clk_sys) disable iff (!nrst)
        osc_tick |=> !osc_tick [*8];
    endproperty
    a_tick_gap: assert property (p_tick_gap) else $error("watchdog ticks too close"); // RULE_07

endmodule : wdrt_osc
`default_nettype wire

// file: wdrt_irq.sv
// Sticky interrupt status with mask and level interrupt output
`timescale 1ns/1ps
`default_nettype none
`include "wdrt_consts.svh"

module wdrt_irq (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire wdrt_pkg::wdrt_byte_t evt,
    input wire logic stat_wr,
    input wire logic mask_wr,
    input wire wdrt_pkg::wdrt_byte_t wdata,
    output wdrt_pkg::wdrt_byte_t stat,
    output wdrt_pkg::wdrt_byte_t mask,
    output logic irq
);
    import wdrt_pkg::*;

    wdrt_irq_st_t st_r;
    wdrt_irq_st_t st_nxt;

    // Write one clears a bit; an event in the same cycle wins
    always_comb begin
        st_nxt = st_r;
        if (stat_wr) begin
            st_nxt.stat = st_r.stat & ~wdata;
        end
        st_nxt.stat = st_nxt.stat | evt;
        if (mask_wr) begin
            st_nxt.mask = wdata;
        end
    end

    // State register
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign stat = st_r.stat;
    assign mask = st_r.mask;
    assign irq = |(st_r.stat & st_r.mask);

    // An event is never lost to a clear in the same cycle
    property p_set_wins;
        @(posedge clk_sys) disable iff (!nrst)
        (evt != `WDRT_BYTE_ZERO) |=> ((stat & $past(evt)) == $past(evt));
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("interrupt event lost"); // RULE_02

endmodule : wdrt_irq
`default_nettype wire

// file: wdrt_top.sv
// Watchdog reload timer: 16-bit down-counter, reload registers, time-out response
// ****************************************
// How it works
// (RULE_01) Counter advances only on watchdog oscillator ticks
// (RULE_02) Terminal count gives reset or interrupt
// (RULE_03) Only on or off; counts until retriggered
// (RULE_04) Refresh instruction starts a stopped watchdog
// (RULE_05) Always-on option at zero runs from reset
// (RULE_06) Reload is high byte over low byte
// (RULE_07) Time-out in ms is reload over ten
// (RULE_08) Reload resets to 0400, about 102 ms
// (RULE_09) Each retrigger reloads the full interval
// (RULE_10) Response choice locked while counter runs
// ****************************************
`timescale 1ns/1ps
`default_nettype none
`include "wdrt_consts.svh"

module wdrt_top #(
    parameter int unsigned OSC_DIV = `WDRT_OSC_DIV
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire wdrt_pkg::wdrt_byte_t addr,
    input wire wdrt_pkg::wdrt_byte_t wdata,
    input wire logic wr,
    input wire logic rd,
    output wdrt_pkg::wdrt_byte_t rdata,
    input wire logic refresh_instr,
    input wire logic always_on_option,
    output logic sys_reset_req,
    output logic irq
);
    import wdrt_pkg::*;

    // ****************************************
    // Declarations
    // ****************************************
    wdrt_st_t st_r;
    wdrt_st_t st_nxt;
    logic osc_tick;
    logic running;
    logic timeout;
    logic [15:0] reload_val;
    wdrt_byte_t irq_evt;
    wdrt_byte_t irq_stat;
    wdrt_byte_t irq_mask;
    logic irq_stat_wr;
    logic irq_mask_wr;

    // ****************************************
    // Submodules
    // ****************************************

    // Stands in for the dedicated low-rate oscillator
    wdrt_osc #(
        .OSC_DIV(OSC_DIV)
    ) u_osc (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .osc_tick(osc_tick)
    );

    // Time-out interrupt status and mask
    wdrt_irq u_irq (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .evt(irq_evt),
        .stat_wr(irq_stat_wr),
        .mask_wr(irq_mask_wr),
        .wdata(wdata),
        .stat(irq_stat),
        .mask(irq_mask),
        .irq(irq)
    );

    // ****************************************
    // Counter control
    // ****************************************

    // Concatenated reload value and the run condition
    assign reload_val = {st_r.rld_hi, st_r.rld_lo}; // RULE_06
    assign running = st_r.run | ~always_on_option; // RULE_05
    assign timeout = running && osc_tick && !refresh_instr
        && (st_r.cnt == `WDRT_CNT_ONE); // RULE_02

    // Bus strobes for the interrupt block
    assign irq_stat_wr = wr && (addr == `WDRT_ADDR_IRQ_STAT);
    assign irq_mask_wr = wr && (addr == `WDRT_ADDR_IRQ_MASK);

    // Time-out event routed to interrupt status when that response is chosen
    always_comb begin
        irq_evt = `WDRT_BYTE_ZERO;
        irq_evt[`WDRT_IRQ_TO_BIT] = timeout && (st_r.resp == WDRT_RESP_INTERRUPT); // RULE_02
    end

    // Next-state logic for counter, registers and read data
    always_comb begin
        st_nxt = st_r;
        st_nxt.rst_req = 1'b0;
        st_nxt.rdata = `WDRT_BYTE_ZERO;

        // Once on, stays on until reset
        if (refresh_instr || !always_on_option) begin
            st_nxt.run = 1'b1; // RULE_03 RULE_04 RULE_05
        end

        // Count only on oscillator ticks; a retrigger restarts the interval
        if (refresh_instr) begin
            st_nxt.cnt = reload_val; // RULE_09
        end else if (running && osc_tick) begin
            if (st_r.cnt == `WDRT_CNT_ONE) begin
                st_nxt.cnt = reload_val;
                st_nxt.rst_req = (st_r.resp == WDRT_RESP_SYS_RESET); // RULE_02
            end else begin
                st_nxt.cnt = 16'(st_r.cnt - `WDRT_CNT_ONE); // RULE_01
            end
        end

        // Register writes; reload bytes take effect at the next reload
        if (wr) begin
            case (addr)
                `WDRT_ADDR_RLD_HI: begin
                    st_nxt.rld_hi = wdata;
                end
                `WDRT_ADDR_RLD_LO: begin
                    st_nxt.rld_lo = wdata;
                end
                `WDRT_ADDR_CTRL: begin
                    if (!running) begin
                        st_nxt.resp = wdata[`WDRT_CTRL_RESP_BIT]; // RULE_10
                    end
                end
                default: begin
                end
            endcase
        end

        // Read data stands in the cycle after the strobe only
        if (rd) begin
            case (addr)
                `WDRT_ADDR_RLD_HI: begin
                    st_nxt.rdata = st_r.rld_hi;
                end
                `WDRT_ADDR_RLD_LO: begin
                    st_nxt.rdata = st_r.rld_lo;
                end
                `WDRT_ADDR_CTRL: begin
                    st_nxt.rdata[`WDRT_CTRL_RESP_BIT] = st_r.resp;
                end
                `WDRT_ADDR_STATUS: begin
                    st_nxt.rdata[`WDRT_STAT_RUN_BIT] = running;
                    st_nxt.rdata[`WDRT_STAT_RESP_BIT] = st_r.resp;
                    st_nxt.rdata[`WDRT_STAT_AO_BIT] = always_on_option;
                end
                `WDRT_ADDR_IRQ_STAT: begin
                    st_nxt.rdata = irq_stat;
                end
                `WDRT_ADDR_IRQ_MASK: begin
                    st_nxt.rdata = irq_mask;
                end
                `WDRT_ADDR_CNT_HI: begin
                    st_nxt.rdata = st_r.cnt[15:8];
                end
                `WDRT_ADDR_CNT_LO: begin
                    st_nxt.rdata = st_r.cnt[7:0];
                end
                default: begin
                    st_nxt.rdata = `WDRT_BYTE_ZERO;
                end
            endcase
        end
    end

    // ****************************************
    // State register
    // ****************************************

    // Reset loads the default reload and response
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            st_r.rld_hi <= `WDRT_RLD_HI_RST; // RULE_08
            st_r.rld_lo <= `WDRT_RLD_LO_RST; // RULE_08
            st_r.resp <= `WDRT_RESP_RST;
            st_r.run <= 1'b0;
            st_r.cnt <= `WDRT_RELOAD_RST;
            st_r.rst_req <= 1'b0;
            st_r.rdata <= `WDRT_BYTE_ZERO;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign rdata = st_r.rdata;
    assign sys_reset_req = st_r.rst_req;

    // ****************************************
    // Checks
    // ****************************************

    // Count holds between oscillator ticks
    property p_tick_only;
        @(posedge clk_sys) disable iff (!nrst)
        (!osc_tick && !refresh_instr) |=> $stable(st_r.cnt);
    endproperty
    a_tick_only: assert property (p_tick_only) else $error("count moved without tick"); // RULE_01

    // Reset response fires the cycle after terminal count
    property p_to_reset;
        @(posedge clk_sys) disable iff (!nrst)
        (timeout && st_r.resp == WDRT_RESP_SYS_RESET && !irq_stat[`WDRT_IRQ_TO_BIT])
            |=> sys_reset_req && !irq_stat[`WDRT_IRQ_TO_BIT];
    endproperty
    a_to_reset: assert property (p_to_reset) else $error("no reset on time-out"); // RULE_02

    // Interrupt response sets the status bit instead
    property p_to_irq;
        @(posedge clk_sys) disable iff (!nrst)
        (timeout && st_r.resp == WDRT_RESP_INTERRUPT)
            |=> irq_stat[`WDRT_IRQ_TO_BIT] && !sys_reset_req;
    endproperty
    a_to_irq: assert property (p_to_irq) else $error("no interrupt on time-out"); // RULE_02

    // Once on, never off again
    property p_stays_on;
        @(posedge clk_sys) disable iff (!nrst)
        st_r.run |=> st_r.run [*4];
    endproperty
    a_stays_on: assert property (p_stays_on) else $error("watchdog turned off"); // RULE_03

    // Refresh instruction enables the watchdog
    property p_refresh_on;
        @(posedge clk_sys) disable iff (!nrst)
        refresh_instr |=> st_r.run;
    endproperty
    a_refresh_on: assert property (p_refresh_on) else $error("refresh did not enable"); // RULE_04

    // Always-on option at zero keeps it running
    property p_ao_run;
        @(posedge clk_sys) disable iff (!nrst)
        !always_on_option |-> running ##1 st_r.run;
    endproperty
    a_ao_run: assert property (p_ao_run) else $error("always-on not honoured"); // RULE_05

    // Retrigger loads the concatenated reload value
    property p_reload;
        @(posedge clk_sys) disable iff (!nrst)
        refresh_instr |=> st_r.cnt == $past(reload_val);
    endproperty
    a_reload: assert property (p_reload) else $error("retrigger reload wrong"); // RULE_06 RULE_09

    // Default reload right after reset release
    property p_rst_default;
        @(posedge clk_sys) disable iff (!nrst)
        !$past(nrst) |-> reload_val == `WDRT_RELOAD_RST;
    endproperty
    a_rst_default: assert property (p_rst_default) else $error("reload default wrong"); // RULE_08

    // Response choice frozen while running
    property p_resp_lock;
        @(posedge clk_sys) disable iff (!nrst)
        running |=> $stable(st_r.resp);
    endproperty
    a_resp_lock: assert property (p_resp_lock) else $error("response changed while on"); // RULE_10

    // Reset request is a single-cycle pulse
    property p_rst_pulse;
        @(posedge clk_sys) disable iff (!nrst)
        sys_reset_req |=> !sys_reset_req;
    endproperty
    a_rst_pulse: assert property (p_rst_pulse) else $error("reset request too long"); // RULE_02

    // Each tick while running takes one off the count, except at count one where it reloads
    property p_count_down;
        @(posedge clk_sys) disable iff (!nrst)
        (running && osc_tick && !refresh_instr && st_r.cnt != `WDRT_CNT_ONE)
            |=> st_r.cnt == 16'($past(st_r.cnt) - `WDRT_CNT_ONE);
    endproperty
    a_count_down: assert property (p_count_down) else $error("count did not step down"); // RULE_01

    // Terminal count starts a fresh interval from the reload value
    property p_to_reload;
        @(posedge clk_sys) disable iff (!nrst)
        timeout |=> st_r.cnt == $past(reload_val);
    endproperty
    a_to_reload: assert property (p_to_reload) else $error("no reload after time-out"); // RULE_09

    // No time-out response without an oscillator tick
    property p_tick_no_rst;
        @(posedge clk_sys) disable iff (!nrst)
        !osc_tick |=> !sys_reset_req;
    endproperty
    a_tick_no_rst: assert property (p_tick_no_rst) else $error("reset without tick"); // RULE_01

    // A stopped watchdog keeps its count
    property p_off_holds;
        @(posedge clk_sys) disable iff (!nrst)
        (!running && !refresh_instr) |=> $stable(st_r.cnt);
    endproperty
    a_off_holds: assert property (p_off_holds) else $error("stopped watchdog counted"); // RULE_03

    // A retrigger on the terminal tick prevents the time-out
    property p_refresh_no_to;
        @(posedge clk_sys) disable iff (!nrst)
        refresh_instr |=> !sys_reset_req;
    endproperty
    a_refresh_no_to: assert property (p_refresh_no_to) else $error("time-out despite retrigger"); // RULE_09

endmodule : wdrt_top
`default_nettype wire

// file: watchdog_reload_timer_test.sv
// Self-checking testbench for the watchdog reload timer
`timescale 1ns/1ps
`default_nettype none
`include "wdrt_consts.svh"

module watchdog_reload_timer_test;
    import wdrt_pkg::*;

    // ****************************************
    // Clock, reset and stimulus signals
    // ****************************************
    localparam int unsigned D = 16;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    wdrt_byte_t addr = 8'h00;
    wdrt_byte_t wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    wdrt_byte_t rdata;
    logic refresh_instr = 1'b0;
    logic always_on_option = 1'b1;
    logic sys_reset_req;
    logic irq;
    int n_errors = 0;
    int checked = 0;
    int n_rst = 0;
    int n;
    wdrt_byte_t row_addr [9];
    wdrt_byte_t row_exp [9];

    // Short oscillator divider keeps time-outs within a short run
    wdrt_top #(.OSC_DIV(D)) dut (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .addr(addr),
        .wdata(wdata),
        .wr(wr),
        .rd(rd),
        .rdata(rdata),
        .refresh_instr(refresh_instr),
        .always_on_option(always_on_option),
        .sys_reset_req(sys_reset_req),
        .irq(irq)
    );

    // 200 MHz system clock
    initial begin
        forever #2.5 clk_sys = ~clk_sys;
    end

    // Counts reset requests seen on the output
    always @(posedge clk_sys) begin
        if (sys_reset_req === 1'b1) n_rst <= n_rst + 1;
    end

    // ****************************************
    // Helper tasks
    // ****************************************
    task automatic check(input logic ok, input string msg);
        checked++;
        if (ok !== 1'b1) begin
            n_errors++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask : check

    task automatic complete_run;
        $display("Checks made: %0d, mismatches: %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : complete_run

    task automatic wr_reg(input wdrt_byte_t a, input wdrt_byte_t d);
        @(posedge clk_sys);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_sys);
        wr <= 1'b0;
    endtask : wr_reg

    // Read data stand one cycle after the strobe, then return to zero
    task automatic rd_reg(input wdrt_byte_t a, input wdrt_byte_t e);
        @(posedge clk_sys);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys);
        rd <= 1'b0;
        #1;
        check(rdata === e, "register read value wrong");
        @(posedge clk_sys);
        #1;
        check(rdata === 8'h00, "read data not back to zero");
    endtask : rd_reg

    task automatic refresh;
        @(posedge clk_sys);
        refresh_instr <= 1'b1;
        @(posedge clk_sys);
        refresh_instr <= 1'b0;
    endtask : refresh

    task automatic do_reset(input logic ao);
        @(posedge clk_sys);
        nrst <= 1'b0;
        always_on_option <= ao;
        repeat (2) @(posedge clk_sys);
        nrst <= 1'b1;
    endtask : do_reset

    // Counts cycles until the chosen output goes high, with a limit
    task automatic wait_sig(input logic sel, input int lim, output int cnt);
        cnt = 0;
        while (cnt < lim) begin
            @(posedge clk_sys);
            #1;
            cnt++;
            if ((sel ? irq : sys_reset_req) === 1'b1) break;
        end
    endtask : wait_sig

    // Hang guard
    initial begin
        #200000;
        n_errors++;
        $display("CHECK FAILED at %0t: run did not finish", $time);
        complete_run();
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        row_addr = '{`WDRT_ADDR_RLD_HI, `WDRT_ADDR_RLD_LO, `WDRT_ADDR_CTRL, `WDRT_ADDR_STATUS,
            `WDRT_ADDR_IRQ_STAT, `WDRT_ADDR_IRQ_MASK, `WDRT_ADDR_CNT_HI, `WDRT_ADDR_CNT_LO, 8'h10};
        row_exp = '{8'h04, 8'h00, 8'h00, 8'h04, 8'h00, 8'h00, 8'h04, 8'h00, 8'h00};
        repeat (2) @(posedge clk_sys);
        nrst <= 1'b1;
        #1;
        check(sys_reset_req === 1'b0 && irq === 1'b0, "outputs not idle after reset");
        // Unmapped and read-only places ignore writes
        wr_reg(8'h10, 8'hFF);
        wr_reg(`WDRT_ADDR_STATUS, 8'hFF);
        for (int i = 0; i < 9; i++) begin
            rd_reg(row_addr[i], row_exp[i]);
        end
        // Response choice is writable while stopped
        wr_reg(`WDRT_ADDR_CTRL, 8'h01);
        rd_reg(`WDRT_ADDR_CTRL, 8'h01);
        wr_reg(`WDRT_ADDR_RLD_HI, 8'h00);
        wr_reg(`WDRT_ADDR_RLD_LO, 8'h03);
        rd_reg(`WDRT_ADDR_STATUS, 8'h06);
        refresh();
        rd_reg(`WDRT_ADDR_STATUS, 8'h07);
        rd_reg(`WDRT_ADDR_CNT_HI, 8'h00);
        // Response choice is locked once running
        wr_reg(`WDRT_ADDR_CTRL, 8'h00);
        rd_reg(`WDRT_ADDR_CTRL, 8'h01);
        // Regular retriggers keep the time-out away
        repeat (8) begin
            refresh();
            repeat (18) @(posedge clk_sys);
        end
        rd_reg(`WDRT_ADDR_IRQ_STAT, 8'h00);
        // Interrupt response: time-out within three ticks of a retrigger
        refresh();
        repeat (3 * D + 4) @(posedge clk_sys);
        rd_reg(`WDRT_ADDR_IRQ_STAT, 8'h01);
        check(irq === 1'b0, "masked interrupt raised");
        wr_reg(`WDRT_ADDR_IRQ_MASK, 8'h01);
        #1;
        check(irq === 1'b1, "unmasked interrupt missing");
        wr_reg(`WDRT_ADDR_IRQ_STAT, 8'h01);
        #1;
        check(irq === 1'b0, "interrupt not cleared");
        check(n_rst == 0, "reset request in interrupt mode");
        // Always-on option at zero: default reload times out with no refresh
        do_reset(1'b0);
        #1;
        check(sys_reset_req === 1'b0 && irq === 1'b0, "outputs not idle after reset");
        wait_sig(1'b0, 1024 * D + 8, n);
        check(n >= 1023 * D && n <= 1024 * D + 4, "default time-out off");
        check(sys_reset_req === 1'b1, "no reset request");
        @(posedge clk_sys);
        #1;
        check(sys_reset_req === 1'b0, "reset request too long");
        rd_reg(`WDRT_ADDR_STATUS, 8'h01);
        // Short reload with reset response
        wr_reg(`WDRT_ADDR_RLD_LO, 8'h02);
        wr_reg(`WDRT_ADDR_RLD_HI, 8'h00);
        refresh();
        wait_sig(1'b0, 3 * D, n);
        check(n >= D && n <= 2 * D + 2, "short time-out off");
        complete_run();
    end

endmodule : watchdog_reload_timer_test
`default_nettype wire
